// *** pkg/pioe_map.svh ***
// Offsets, field positions and reset values of the poll controller
`ifndef PIOE_MAP_SVH
`define PIOE_MAP_SVH

// ****************************************************************
// Register offsets (scratch-pad style status, plus own controls)
// ****************************************************************
`define PIOE_ADDR_TRIG0      8'h80
`define PIOE_ADDR_TRIG1      8'h81
`define PIOE_ADDR_TRIG2      8'h82
`define PIOE_ADDR_TRIG3      8'h83
`define PIOE_ADDR_MODE       8'h84
`define PIOE_ADDR_RUNSLOT    8'h85
`define PIOE_ADDR_STATUS     8'h87
`define PIOE_ADDR_IN_EN_LO   8'h90
`define PIOE_ADDR_IN_EN_HI   8'h91
`define PIOE_ADDR_IN_LVL_LO  8'h92
`define PIOE_ADDR_IN_LVL_HI  8'h93
`define PIOE_ADDR_OUT_EN_LO  8'h94
`define PIOE_ADDR_OUT_EN_HI  8'h95
`define PIOE_ADDR_OUT_LVL_LO 8'h96
`define PIOE_ADDR_OUT_LVL_HI 8'h97

// ****************************************************************
// Status register bit positions
// ****************************************************************
`define PIOE_ST_OUT_EN     0
`define PIOE_ST_IN_DEF     1
`define PIOE_ST_RUN_EN     2
`define PIOE_ST_LATCH      3
`define PIOE_ST_TRIG       4
`define PIOE_ST_LATCHED    5
`define PIOE_ST_WAIT_EVT   6
`define PIOE_ST_ACTIVE     7

// ****************************************************************
// Mode field layout and reset values
// ****************************************************************
`define PIOE_MODE_LATCH_BIT 3
`define PIOE_MODE_RESET     4'h0
`define PIOE_RUNSLOT_RESET  3'h0

`endif

// *** pkg/pioe_pkg.sv ***
// Types shared by the poll controller files
package pioe_pkg;

  // Base operation selected by the low three mode bits
  typedef enum logic [2:0] {
    PIOE_OP_OFF_CLEAR = 3'h0,
    PIOE_OP_OFF_KEEP  = 3'h1,
    PIOE_OP_OUT_WAIT  = 3'h2,
    PIOE_OP_RUN_ONLY  = 3'h3,
    PIOE_OP_ALL       = 3'h4,
    PIOE_OP_CLR_IN    = 3'h5,
    PIOE_OP_CLR_OUT   = 3'h6,
    PIOE_OP_CLR_BOTH  = 3'h7
  } pioe_op_t;

  // Controller sequencing state (one-hot)
  typedef enum logic [2:0] {
    PIOE_ST_IDLE  = 3'b001,
    PIOE_ST_OUT   = 3'b010,
    PIOE_ST_RUN   = 3'b100
  } pioe_state_t;

endpackage : pioe_pkg

// *** rtl/pioe_match.sv ***
// Input match detector for the polled pins
`timescale 1ns/1ps

module pioe_match
  import pioe_pkg::*;
#(
  parameter int N = 32
)
(
  // Pin samples and configuration
  input  wire logic [N-1:0] pins,
  input  wire logic [N-1:0] in_en,
  input  wire logic [N-1:0] in_lvl,
  // Results
  output logic      [N-1:0] hit,
  output logic              any_hit
);

  // A pin hits when defined as input and at its target level
  always_comb
  begin
    hit     = in_en & ~(pins ^ in_lvl);
    any_hit = |hit;
  end

endmodule : pioe_match

// *** rtl/pioe_outdrv.sv ***
// Output driver for the polled output pins
`timescale 1ns/1ps

module pioe_outdrv
  import pioe_pkg::*;
#(
  parameter int N = 32
)
(
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         ce,
  // Control
  input  wire logic         update,
  input  wire logic         match,
  input  wire logic         latch_mode,
  input  wire logic         relatch,
  input  wire logic [N-1:0] out_en,
  input  wire logic [N-1:0] out_lvl,
  // Pins
  output logic      [N-1:0] pin_out,
  output logic              latched
);

  // Outputs only change on a poll update; erase leaves levels alone
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      pin_out <= '0;
    else if (ce && update)
    begin
      if (match)
        pin_out <= (pin_out & ~out_en) | (out_lvl & out_en);
      else if (!latch_mode || !latched)
        pin_out <= (pin_out & ~out_en) | (~out_lvl & out_en);
    end
  end

  // Latch record, cleared by a fresh mode write
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      latched <= 1'b0;
    else if (ce)
    begin
      if (update && match && latch_mode)
        latched <= 1'b1;
      else if (relatch)
        latched <= 1'b0;
    end
  end

endmodule : pioe_outdrv

// *** rtl/pioe_ctrl.sv ***
// Polled I/O event controller: mode, configuration, status and actions
`timescale 1ns/1ps
`include "pioe_map.svh"

module pioe_ctrl
  import pioe_pkg::*;
#(
  parameter int N = 32
)
(
  // Clock, reset, enable
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         ce,
  // Register port
  input  wire logic [7:0]   addr,
  input  wire logic [7:0]   wdata,
  input  wire logic         wr,
  input  wire logic         rd,
  output logic      [7:0]   rdata,
  // Interpreter interface
  input  wire logic         instr_gap,
  input  wire logic         wait_req,
  output logic              wait_done,
  output logic              run_req,
  output logic      [2:0]   run_slot,
  // I/O pins
  input  wire logic [N-1:0] pin_in,
  output logic      [N-1:0] pin_out,
  output logic      [N-1:0] pin_oe
);

  // ****************************************************************
  // Configuration and mode state
  // ****************************************************************
  logic [3:0]   mode;
  logic [N-1:0] in_en;
  logic [N-1:0] in_lvl;
  logic [N-1:0] out_en;
  logic [N-1:0] out_lvl;
  logic [N-1:0] trig;
  logic         wait_evt;
  logic         fired;
  logic [N-1:0] hit;
  logic         any_hit;
  logic         latched;
  logic         out_update;
  logic         mode_wr;
  logic         poll_pt;
  pioe_state_t  state;
  pioe_state_t  next_state;
  pioe_op_t     op;
  pioe_op_t     wop;

  // Decoded actions of a mode
  function automatic logic is_active(input pioe_op_t o);
    return (o == PIOE_OP_OUT_WAIT) || (o == PIOE_OP_RUN_ONLY) ||
           (o == PIOE_OP_ALL);
  endfunction : is_active

  function automatic logic out_on(input pioe_op_t o);
    return (o == PIOE_OP_OUT_WAIT) || (o == PIOE_OP_ALL);
  endfunction : out_on

  function automatic logic run_on(input pioe_op_t o);
    return (o == PIOE_OP_RUN_ONLY) || (o == PIOE_OP_ALL);
  endfunction : run_on

  // Byte lane helper for the 16-bit-per-group configuration words
  function automatic logic [N-1:0] put_byte(input logic [N-1:0] v,
                                            input int idx,
                                            input logic [7:0] b);
    logic [N-1:0] r;
    r = v;
    for (int i = 0; i < 8; i++)
      if (idx * 8 + i < N)
        r[idx * 8 + i] = b[i];
    return r;
  endfunction : put_byte

  function automatic logic [7:0] get_byte(input logic [N-1:0] v,
                                          input int idx);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < 8; i++)
      if (idx * 8 + i < N)
        r[i] = v[idx * 8 + i];
    return r;
  endfunction : get_byte

  assign op      = pioe_op_t'(mode[2:0]);
  assign wop     = pioe_op_t'(wdata[2:0]);
  assign mode_wr = wr && (addr == `PIOE_ADDR_MODE);
  assign poll_pt = instr_gap && is_active(op) && (state == PIOE_ST_IDLE);

  // ****************************************************************
  // Sub-blocks
  // ****************************************************************
  pioe_match #(.N(N)) u_match
  (
    .pins    (pin_in),
    .in_en   (in_en),
    .in_lvl  (in_lvl),
    .hit     (hit),
    .any_hit (any_hit)
  );

  pioe_outdrv #(.N(N)) u_outdrv
  (
    .clk        (clk),
    .rst        (rst),
    .ce         (ce),
    .update     (out_update),
    .match      (any_hit),
    .latch_mode (mode[`PIOE_MODE_LATCH_BIT]),
    .relatch    (mode_wr),
    .out_en     (out_en),
    .out_lvl    (out_lvl),
    .pin_out    (pin_out),
    .latched    (latched)
  );

  // Polled outputs stay driven whether polling runs or not
  assign pin_oe = out_en;

  // ****************************************************************
  // Sequencer: output update first, run request after
  // ****************************************************************
  always_comb
  begin
    next_state = state;
    case (state)
      PIOE_ST_IDLE:
        if (instr_gap && is_active(op) && any_hit)
          next_state = out_on(op) ? PIOE_ST_OUT :
                       ((run_on(op) && !fired) ? PIOE_ST_RUN : PIOE_ST_IDLE);
        else if (instr_gap && is_active(op) && out_on(op))
          next_state = PIOE_ST_OUT;
      PIOE_ST_OUT:
        next_state = (run_on(op) && !fired && any_hit) ?
                     PIOE_ST_RUN : PIOE_ST_IDLE;
      PIOE_ST_RUN:
        next_state = PIOE_ST_IDLE;
      default:
        next_state = PIOE_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      state <= PIOE_ST_IDLE;
    else if (ce)
      state <= mode_wr ? PIOE_ST_IDLE : next_state;
  end

  // Output pins refresh each poll in the out_on modes, following the match unless latched
  // A mode write cancels a pending refresh, so an erase never moves levels
  assign out_update = (state == PIOE_ST_OUT) && !mode_wr;
  // Pins defined while outputs enabled take part here at once

  // Run request pulse and one-shot record
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      run_req <= 1'b0;
    else if (ce)
      run_req <= (state == PIOE_ST_RUN) && !mode_wr;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      fired <= 1'b0;
    else if (ce)
    begin
      if (mode_wr && wdata[2:0] <= 3'h4)
        fired <= 1'b0;
      else if (state == PIOE_ST_RUN)
        fired <= 1'b1;
    end
  end

  // ****************************************************************
  // Mode register
  // ****************************************************************
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      mode <= `PIOE_MODE_RESET;
    else if (ce)
    begin
      if (mode_wr)
      begin
        if (wdata[2:0] <= 3'h4)
          mode <= wdata[3:0];
        else
          mode <= {wdata[3], mode[2:0]};
      end
      else if (state == PIOE_ST_RUN)
      begin
        if (op == PIOE_OP_RUN_ONLY)
          mode <= {mode[3], PIOE_OP_OFF_KEEP};
        else
          mode <= {mode[3], PIOE_OP_OUT_WAIT};
      end
    end
  end

  // ****************************************************************
  // Pin configuration and run slot
  // ****************************************************************
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      in_en  <= '0;
      in_lvl <= '0;
    end
    else if (ce)
    begin
      if (mode_wr && (wop == PIOE_OP_OFF_CLEAR || wop == PIOE_OP_CLR_IN ||
                      wop == PIOE_OP_CLR_BOTH))
      begin
        in_en  <= '0;
        in_lvl <= '0;
      end
      else if (wr)
      begin
        case (addr)
          `PIOE_ADDR_IN_EN_LO:  in_en  <= put_byte(in_en, 0, wdata);
          `PIOE_ADDR_IN_EN_HI:  in_en  <= put_byte(in_en, 1, wdata);
          `PIOE_ADDR_IN_LVL_LO: in_lvl <= put_byte(in_lvl, 0, wdata);
          `PIOE_ADDR_IN_LVL_HI: in_lvl <= put_byte(in_lvl, 1, wdata);
          default: ;
        endcase
      end
    end
  end

  // Output erase clears enables and target levels; pin levels stay put
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      out_en  <= '0;
      out_lvl <= '0;
    end
    else if (ce)
    begin
      if (mode_wr && (wop == PIOE_OP_OFF_CLEAR || wop == PIOE_OP_CLR_OUT ||
                      wop == PIOE_OP_CLR_BOTH))
      begin
        out_en  <= '0;
        out_lvl <= '0;
      end
      else if (wr)
      begin
        case (addr)
          `PIOE_ADDR_OUT_EN_LO:  out_en  <= put_byte(out_en, 0, wdata);
          `PIOE_ADDR_OUT_EN_HI:  out_en  <= put_byte(out_en, 1, wdata);
          `PIOE_ADDR_OUT_LVL_LO: out_lvl <= put_byte(out_lvl, 0, wdata);
          `PIOE_ADDR_OUT_LVL_HI: out_lvl <= put_byte(out_lvl, 1, wdata);
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      run_slot <= `PIOE_RUNSLOT_RESET;
    else if (ce && wr && addr == `PIOE_ADDR_RUNSLOT)
      run_slot <= wdata[2:0];
  end

  // ****************************************************************
  // Event status: trigger flags and wait event
  // ****************************************************************
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      trig <= '0;
    else if (ce)
    begin
      // A mode write clears, but a hit in the same cycle still sets
      if (mode_wr)
        trig <= poll_pt ? hit : '0;
      else if (poll_pt)
        trig <= trig | hit;
    end
  end

  // Set wins over the clear by a mode write
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      wait_evt <= 1'b0;
    else if (ce)
    begin
      if (instr_gap && out_on(op) && any_hit && state == PIOE_ST_IDLE)
        wait_evt <= 1'b1;
      else if (mode_wr)
        wait_evt <= 1'b0;
    end
  end

  // Wait released by the event in output/wait modes
  assign wait_done = wait_req && wait_evt && out_on(op);

  // ****************************************************************
  // Read port, data one cycle after the strobe
  // ****************************************************************
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      rdata <= 8'h00;
    else if (ce)
    begin
      rdata <= 8'h00;
      if (rd)
      begin
        case (addr)
          `PIOE_ADDR_TRIG0:      rdata <= get_byte(trig, 0);
          `PIOE_ADDR_TRIG1:      rdata <= get_byte(trig, 1);
          `PIOE_ADDR_TRIG2:      rdata <= get_byte(trig, 2);
          `PIOE_ADDR_TRIG3:      rdata <= get_byte(trig, 3);
          `PIOE_ADDR_MODE:       rdata <= {4'h0, mode};
          `PIOE_ADDR_RUNSLOT:    rdata <= {5'h00, run_slot};
          `PIOE_ADDR_STATUS:
          begin
            rdata[`PIOE_ST_OUT_EN]   <= out_on(op);
            rdata[`PIOE_ST_IN_DEF]   <= |in_en;
            rdata[`PIOE_ST_RUN_EN]   <= run_on(op) && !fired;
            rdata[`PIOE_ST_LATCH]    <= mode[`PIOE_MODE_LATCH_BIT];
            rdata[`PIOE_ST_TRIG]     <= |trig;
            rdata[`PIOE_ST_LATCHED]  <= latched;
            rdata[`PIOE_ST_WAIT_EVT] <= wait_evt;
            rdata[`PIOE_ST_ACTIVE]   <= is_active(op);
          end
          `PIOE_ADDR_IN_EN_LO:   rdata <= get_byte(in_en, 0);
          `PIOE_ADDR_IN_EN_HI:   rdata <= get_byte(in_en, 1);
          `PIOE_ADDR_IN_LVL_LO:  rdata <= get_byte(in_lvl, 0);
          `PIOE_ADDR_IN_LVL_HI:  rdata <= get_byte(in_lvl, 1);
          `PIOE_ADDR_OUT_EN_LO:  rdata <= get_byte(out_en, 0);
          `PIOE_ADDR_OUT_EN_HI:  rdata <= get_byte(out_en, 1);
          `PIOE_ADDR_OUT_LVL_LO: rdata <= get_byte(out_lvl, 0);
          `PIOE_ADDR_OUT_LVL_HI: rdata <= get_byte(out_lvl, 1);
          default:               rdata <= 8'h00;
        endcase
      end
    end
  end

endmodule : pioe_ctrl

// *** verification/pioe_ctrl_properties.sv ***
// Concurrent checks on the poll controller ports
`timescale 1ns/1ps
`include "pioe_map.svh"

module pioe_ctrl_props
#(
  parameter int N = 32
)
(
  // Clock and reset
  input wire logic         clk,
  input wire logic         rst,
  input wire logic         ce,
  // Register port
  input wire logic [7:0]   addr,
  input wire logic [7:0]   wdata,
  input wire logic         wr,
  input wire logic         rd,
  input wire logic [7:0]   rdata,
  // Interpreter side
  input wire logic         instr_gap,
  input wire logic         wait_req,
  input wire logic         wait_done,
  input wire logic         run_req,
  input wire logic [2:0]   run_slot,
  // Pins
  input wire logic [N-1:0] pin_in,
  input wire logic [N-1:0] pin_out,
  input wire logic [N-1:0] pin_oe
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // ****************************************************************
  // Sequences and properties
  // ****************************************************************
  sequence s_mode_set;
    wr && addr == `PIOE_ADDR_MODE && wdata[7:4] == 4'h0 && wdata[2:0] < 3'h5;
  endsequence
  sequence s_mode_get;
    rd && addr == `PIOE_ADDR_MODE;
  endsequence
  sequence s_clear_wr;
    wr && addr == `PIOE_ADDR_MODE && wdata[2:0] >= 3'h5;
  endsequence
  property p_mode_readback;
    s_mode_set ##2 s_mode_get |=> rdata == $past(wdata, 3);
  endproperty
  property p_rdata_idle;
    !$past(rd) |-> rdata == 8'h00;
  endproperty
  property p_run_once;
    run_req |=> !run_req [*6];
  endproperty
  property p_clear_keeps_out;
    s_clear_wr |=> $stable(pin_out);
  endproperty
  property p_wait_qual;
    wait_done |-> wait_req;
  endproperty
  property p_out_on_poll;
    $changed(pin_out) |-> $past(instr_gap, 2) || $past(instr_gap, 3);
  endproperty
  property p_run_timing;
    run_req |-> $past(instr_gap, 2) || $past(instr_gap, 3);
  endproperty
  property p_oe_by_write;
    $changed(pin_oe) |-> $past(wr);
  endproperty
  property p_reset_clean;
    $fell(rst) |-> pin_oe == '0 && pin_out == '0 && !run_req;
  endproperty

  // Assertions on the properties above
  a_mode_readback: assert property (p_mode_readback)
    else $error("mode readback differs from written value");
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data not zero outside read answer");
  a_run_once: assert property (p_run_once)
    else $error("run request repeated");
  a_clear_keeps_out: assert property (p_clear_keeps_out)
    else $error("erase write changed output levels");
  a_wait_qual: assert property (p_wait_qual)
    else $error("wait released without wait request");
  a_out_on_poll: assert property (p_out_on_poll)
    else $error("outputs changed away from a poll point");
  a_run_timing: assert property (p_run_timing)
    else $error("run request not tied to a poll point");
  a_oe_by_write: assert property (p_oe_by_write)
    else $error("output enables changed without a write");
  a_reset_clean: assert property (p_reset_clean)
    else $error("pins or run request not clear after reset");
endmodule : pioe_ctrl_props

bind pioe_ctrl pioe_ctrl_props #(.N(N)) chk_u (
  .clk(clk), .rst(rst), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr),
  .rd(rd), .rdata(rdata), .instr_gap(instr_gap), .wait_req(wait_req),
  .wait_done(wait_done), .run_req(run_req), .run_slot(run_slot),
  .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe)
);

// *** verification/pioe_panel.sv ***
// Switch and indicator panel wired to the controller pins
`timescale 1ns/1ps

module pioe_panel
#(
  parameter int N = 32
)
(
  // From the controller
  input  wire logic [N-1:0] pin_out,
  input  wire logic [N-1:0] pin_oe,
  // Switch positions, pulled up when open
  input  wire logic [N-1:0] sw,
  // To the controller and the bench
  output logic      [N-1:0] pin_in,
  output logic      [N-1:0] lamp
);
  // Driven pins read back their own level, the rest see the switches
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & sw);
  // Indicators light only while their pin is driven high
  assign lamp = pin_oe & pin_out;
endmodule : pioe_panel

// *** verification/testbench.sv ***
// Self-checking bench for the poll controller
`timescale 1ns/1ps
`include "pioe_map.svh"

module testbench;
  logic         clk;
  logic         rst;
  logic         ce;
  logic [7:0]   addr;
  logic [7:0]   wdata;
  logic         wr;
  logic         rd;
  logic [7:0]   rdata;
  logic         instr_gap;
  logic         wait_req;
  logic         wait_done;
  logic         run_req;
  logic [2:0]   run_slot;
  logic [31:0]  pin_in;
  logic [31:0]  pin_out;
  logic [31:0]  pin_oe;
  logic [31:0]  sw;
  logic [31:0]  lamp;
  logic [31:0]  out_at_run;
  logic [7:0]   exp_mode;
  int           n_fail = 0;
  int           total_checks = 0;
  int           n_run = 0;

  pioe_ctrl #(.N(32)) dut_u (.clk(clk), .rst(rst), .ce(ce), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .instr_gap(instr_gap),
    .wait_req(wait_req), .wait_done(wait_done), .run_req(run_req),
    .run_slot(run_slot), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe));
  pioe_panel #(.N(32)) pan_u (.pin_out(pin_out), .pin_oe(pin_oe), .sw(sw),
    .pin_in(pin_in), .lamp(lamp));

  // ****************************************************************
  // Clock, monitor and tasks
  // ****************************************************************
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Count run pulses and keep the pin levels seen with each
  always @(posedge clk)
  begin
    if (run_req === 1'b1)
    begin
      n_run      <= n_run + 1;
      out_at_run <= pin_out;
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                       input string what);
    total_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask : wr_reg

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e,
                        input logic [7:0] m, input string what);
    @(posedge clk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    check({24'h0, rdata & m}, {24'h0, e}, what);
  endtask : rd_chk

  // One poll point with switch 0 set to s, then let the answer settle
  task automatic gap(input logic s);
    @(posedge clk);
    sw[0]     <= s;
    instr_gap <= 1'b1;
    @(posedge clk);
    instr_gap <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
  endtask : gap

  // Pin 0 polled for low, pin 1 driven high on a match
  task automatic setup;
    wr_reg(`PIOE_ADDR_IN_EN_LO, 8'h01);
    wr_reg(`PIOE_ADDR_OUT_EN_LO, 8'h02);
    wr_reg(`PIOE_ADDR_OUT_LVL_LO, 8'h02);
  endtask : setup

  task automatic conclude;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : conclude

  // Watchdog against a hang
  initial
  begin
    repeat (4000) @(posedge clk);
    n_fail++;
    conclude();
  end

  // ****************************************************************
  // Test sequence
  // ****************************************************************
  initial
  begin
    rst       = 1'b1;
    ce        = 1'b1;
    addr      = 8'h00;
    wdata     = 8'h00;
    wr        = 1'b0;
    rd        = 1'b0;
    instr_gap = 1'b0;
    wait_req  = 1'b0;
    sw        = 32'hFFFF_FFFF;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rd_chk(`PIOE_ADDR_MODE, 8'h00, 8'hFF, "reset mode");
    rd_chk(`PIOE_ADDR_STATUS, 8'h00, 8'hFF, "reset status");
    wr_reg(8'h86, 8'h5A);
    rd_chk(8'h86, 8'h00, 8'hFF, "unmapped");
    setup();
    wr_reg(`PIOE_ADDR_RUNSLOT, 8'h05);
    // Real-time output mode
    wr_reg(`PIOE_ADDR_MODE, 8'h02);
    gap(1'b1);
    check(pin_out, 32'h0000_0000, "out idle");
    @(posedge clk);
    sw[0] <= 1'b0;
    repeat (6) @(posedge clk);
    #1;
    check(pin_out, 32'h0000_0000, "out between gaps");
    gap(1'b0);
    check(lamp, 32'h0000_0002, "lamp on");
    rd_chk(`PIOE_ADDR_TRIG0, 8'h01, 8'hFF, "trigger");
    rd_chk(`PIOE_ADDR_STATUS, 8'h40, 8'h40, "wait flag");
    @(posedge clk);
    wait_req <= 1'b1;
    @(posedge clk);
    #1;
    check({31'h0, wait_done}, 32'h0000_0001, "wait done");
    gap(1'b1);
    check(pin_out, 32'h0000_0000, "out revert");
    check(32'(n_run), 32'h0000_0000, "no run");
    // Kept but inactive, then resumed
    wr_reg(`PIOE_ADDR_MODE, 8'h01);
    check({31'h0, wait_done}, 32'h0000_0000, "wait cleared");
    gap(1'b0);
    check(pin_out, 32'h0000_0000, "no poll");
    check(pin_oe, 32'h0000_0002, "oe kept");
    wr_reg(`PIOE_ADDR_MODE, 8'h02);
    gap(1'b0);
    check(pin_out, 32'h0000_0002, "resumed");
    // Run only
    wr_reg(`PIOE_ADDR_MODE, 8'h03);
    gap(1'b1);
    check(pin_out, 32'h0000_0002, "no out action");
    gap(1'b0);
    check(32'(n_run), 32'h0000_0001, "run fired");
    check({29'h0, run_slot}, 32'h0000_0005, "run slot");
    rd_chk(`PIOE_ADDR_MODE, 8'h01, 8'hFF, "after run 3");
    gap(1'b0);
    check(32'(n_run), 32'h0000_0001, "no rerun");
    // All actions
    wr_reg(`PIOE_ADDR_MODE, 8'h04);
    gap(1'b1);
    check(pin_out, 32'h0000_0000, "out action");
    gap(1'b0);
    check(32'(n_run), 32'h0000_0002, "run fired");
    check(out_at_run, 32'h0000_0002, "out first");
    rd_chk(`PIOE_ADDR_MODE, 8'h02, 8'hFF, "after run 4");
    rd_chk(`PIOE_ADDR_STATUS, 8'hD3, 8'hFF, "status run 4");
    gap(1'b1);
    check(pin_out, 32'h0000_0000, "still follows");
    // Clock enable low: a poll point passes unseen
    @(posedge clk);
    ce <= 1'b0;
    gap(1'b0);
    check(pin_out, 32'h0000_0000, "frozen");
    @(posedge clk);
    ce <= 1'b1;
    gap(1'b0);
    check(32'(n_run), 32'h0000_0002, "run off");
    // Erase codes
    wr_reg(`PIOE_ADDR_MODE, 8'h06);
    check(pin_oe, 32'h0000_0000, "out erased");
    check(pin_out, 32'h0000_0002, "level kept");
    rd_chk(`PIOE_ADDR_MODE, 8'h02, 8'h07, "mode kept");
    wr_reg(`PIOE_ADDR_OUT_EN_LO, 8'h02);
    wr_reg(`PIOE_ADDR_OUT_LVL_LO, 8'h02);
    gap(1'b1);
    check(pin_out, 32'h0000_0000, "new output");
    wr_reg(`PIOE_ADDR_MODE, 8'h05);
    rd_chk(`PIOE_ADDR_IN_EN_LO, 8'h00, 8'hFF, "in erased");
    wr_reg(`PIOE_ADDR_MODE, 8'h07);
    rd_chk(`PIOE_ADDR_OUT_EN_LO, 8'h00, 8'hFF, "both erased");
    rd_chk(`PIOE_ADDR_MODE, 8'h02, 8'hFF, "mode kept");
    // Latched outputs, then full stop
    setup();
    wr_reg(`PIOE_ADDR_MODE, 8'h0A);
    gap(1'b0);
    gap(1'b1);
    check(pin_out, 32'h0000_0002, "latched");
    rd_chk(`PIOE_ADDR_STATUS, 8'h28, 8'h28, "latch status");
    wr_reg(`PIOE_ADDR_MODE, 8'h00);
    rd_chk(`PIOE_ADDR_IN_EN_LO, 8'h00, 8'hFF, "in cleared");
    check(pin_oe, 32'h0000_0000, "out cleared");
    // Every mode code through the mode register
    exp_mode = 8'h00;
    for (int v = 0; v < 16; v++)
    begin
      wr_reg(`PIOE_ADDR_MODE, 8'(v));
      exp_mode = (v % 8 < 5) ? 8'(v) : {4'h0, 1'(v / 8), exp_mode[2:0]};
      rd_chk(`PIOE_ADDR_MODE, exp_mode, 8'hFF, "mode code");
    end
    conclude();
  end
endmodule : testbench
